// ===== vii_pkg.sv
package vii_pkg;

   // ********
   // Register map (byte addresses)
   // ********
   localparam logic [7:0] VII_CMD_OFS = 8'h00;
   localparam logic [7:0] VII_STATUS_OFS = 8'h04;
   localparam logic [7:0] VII_PEND_OFS = 8'h08;
   localparam logic [7:0] VII_LEVEN_OFS = 8'h0C;
   localparam logic [7:0] VII_IIE_OFS = 8'h10;
   localparam logic [7:0] VII_IIC_OFS = 8'h14;
   localparam logic [7:0] VII_PES_OFS = 8'h18;
   localparam logic [7:0] VII_PEA_OFS = 8'h1C;
   localparam logic [7:0] VII_IDENT_OFS = 8'h20;
   localparam logic [7:0] VII_VECTOR_OFS = 8'h24;
   localparam logic [7:0] VII_IRQ_STAT_OFS = 8'h28;
   localparam logic [7:0] VII_IRQ_MASK_OFS = 8'h2C;
   localparam logic [7:0] VII_PREV_OFS = 8'h30;

   // ********
   // Field positions and fixed values
   // ********
   localparam int VII_CMD_ON_BIT = 0;
   localparam int VII_CMD_OFF_BIT = 1;
   localparam int VII_CMD_GIVEUP_BIT = 2;
   localparam int VII_IRQ_IDENT_BIT = 0;
   localparam int VII_IRQ_IOX_BIT = 1;
   localparam int VII_IRQ_LEVEL_BIT = 2;
   localparam int VII_IRQ_INTERNAL_BIT = 3;
   localparam int VII_IOX_SRC_BIT = 7;
   localparam int VII_PTY_SRC_BIT = 8;
   localparam int VII_MOR_SRC_BIT = 9;
   localparam logic [3:0] VII_LEVEL_INTERNAL = 4'hE;
   localparam logic [3:0] VII_LEVEL_VEC_LO = 4'hA;
   localparam logic [3:0] VII_LEVEL_VEC_HI = 4'hD;
   localparam logic [15:0] VII_RESET_WORD = 16'h0000;
   localparam logic [3:0] VII_RESET_LEVEL = 4'h0;
   localparam logic [3:0] VII_RESET_IRQ = 4'h0;
   localparam logic [1:0] VII_RESP_OKAY = 2'h0;
   localparam logic [1:0] VII_RESP_SLVERR = 2'h2;

   // ********
   // Timing
   // ********
   localparam int VII_CLK_PERIOD_NS = 50;
   localparam int VII_IDENT_TIMEOUT_NS = 10000;
   localparam int VII_IDENT_TIMEOUT_CYCLES = VII_IDENT_TIMEOUT_NS / VII_CLK_PERIOD_NS;

   // ********
   // Types
   // ********
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] data;
      logic [3:0] strb;
   } vii_wr_type;

   typedef enum logic [1:0] {
      VII_IDLE = 2'b00,
      VII_ASK = 2'b01,
      VII_RELEASE = 2'b10
   } vii_ident_state_type;

   // Any address that is not a mapped word answers with an error
   function automatic logic vii_addr_ok(input logic [7:0] addr);
      vii_addr_ok = (addr[1:0] == 2'h0) && (addr <= VII_PREV_OFS);
   endfunction

   // Byte-lane merge for 16-bit registers
   function automatic logic [15:0] vii_merge16(input logic [15:0] old, input logic [31:0] data,
                                               input logic [3:0] strb);
      vii_merge16 = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
   endfunction

endpackage

// ===== vii_sync.sv
`timescale 1ns/1ns
`default_nettype none
module vii_sync #(
   parameter int WIDTH = 1
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;

   // Two-flop synchroniser; stage1 feeds only the second flop
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stage1 <= '0;
         sync_out <= '0;
      end else begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end
endmodule
`default_nettype wire

// ===== vii_axil.sv
`timescale 1ns/1ns
`default_nettype none
module vii_axil
   import vii_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output vii_wr_type wr,
   output logic wr_en,
   output logic [7:0] rd_addr,
   output logic rd_en,
   input wire logic [31:0] rd_data
);
   logic aw_full;
   logic w_full;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;

   // ********
   // Handshake decode
   // ********
   // Address and data are held separately so either may come first
   assign s_axi_awready = !aw_full && !s_axi_bvalid;
   assign s_axi_wready = !w_full && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign wr_en = aw_full && w_full && !s_axi_bvalid;
   assign wr = '{addr: aw_addr, data: w_data, strb: w_strb};
   assign rd_en = s_axi_arvalid && s_axi_arready;
   assign rd_addr = s_axi_araddr;

   // Write channel capture and response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full <= 1'b0;
         w_full <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= VII_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_en) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= vii_addr_ok(aw_addr) ? VII_RESP_OKAY : VII_RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Read channel: data registered at the address handshake
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= VII_RESP_OKAY;
      end else if (rd_en) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_data;
         s_axi_rresp <= vii_addr_ok(s_axi_araddr) ? VII_RESP_OKAY : VII_RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ===== vii_top.sv
// What this block does
// - On entering level 14, remember the level that ran before in previous_level_reg.
// - Up to 2048 vectored sources, each with its own 11-bit response code.
// - Vectored requests attach only to levels 13, 12, 11 and 10.
// - A vectored request on a level sets that level's pending flag bit.
// - Identify starts a search on a level; first device returns code, clears itself.
// - The returned code is the branch value selecting the device's driver.
// - After power-up, internal enable, level enable and current level are zero.
// - Cause, parity status and address start blocked; reading cause and status unblocks.
// - No bus data ready reply to identify raises the io exchange internal interrupt.
// - Give-up-priority clears the pending flag of the running level.
// - Reading cause code returns bits 0 to 3, upper bits zero, then clears it.
//
// Chosen here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
module vii_top
   import vii_pkg::*;
#(
   parameter int CODE_W = 11,
   parameter int TIMEOUT_CYCLES = VII_IDENT_TIMEOUT_CYCLES
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [3:0] dev_request,
   input wire logic [10:0] internal_event,
   input wire logic [15:0] parity_status_in,
   input wire logic [15:0] parity_address_in,
   output logic ident_request,
   output logic [1:0] ident_level,
   input wire logic [CODE_W-1:0] ident_code,
   input wire logic bus_data_ready_reply,
   output logic [3:0] current_level,
   output logic interrupts_on,
   output logic [CODE_W-1:0] branch_vector,
   output logic irq
);
   localparam int SYNC_W = 4 + 11 + 16 + 16 + CODE_W + 1;

   // ********
   // Declarations
   // ********
   vii_wr_type wr;
   logic wr_en;
   logic rd_en;
   logic [7:0] rd_addr;
   logic [31:0] rd_data;
   logic [SYNC_W-1:0] sync_out;
   logic [3:0] dev_req_s;
   logic [10:0] event_s;
   logic [15:0] pstat_s;
   logic [15:0] paddr_s;
   logic [CODE_W-1:0] code_s;
   logic ready_s;
   logic [15:0] pending_level_flags;
   logic [15:0] level_enable_mask;
   logic [10:0] internal_source_enable;
   logic [3:0] internal_cause_code;
   logic [15:0] parity_fault_status;
   logic [15:0] parity_fault_address;
   logic [3:0] previous_level_reg;
   logic regs_blocked;
   logic cause_read_seen;
   logic status_read_seen;
   logic vector_valid;
   logic [3:0] irq_status;
   logic [3:0] irq_mask;
   vii_ident_state_type ident_state;
   logic [15:0] timer;
   logic [15:0] next_pending;
   logic [3:0] next_top;
   logic [3:0] next_cause;

   // ********
   // Bus slave and input synchronisers
   // ********
   vii_axil u_axil (
      .aclk(aclk),
      .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .wr(wr),
      .wr_en(wr_en),
      .rd_addr(rd_addr),
      .rd_en(rd_en),
      .rd_data(rd_data)
   );

   // All non-AXI input pins come from outside the clock domain
   vii_sync #(.WIDTH(SYNC_W)) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .async_in({dev_request, internal_event, parity_status_in, parity_address_in, ident_code,
                 bus_data_ready_reply}),
      .sync_out(sync_out)
   );
   assign {dev_req_s, event_s, pstat_s, paddr_s, code_s, ready_s} = sync_out;

   // ********
   // Decoded strobes
   // ********
   wire wr_cmd = wr_en && (wr.addr == VII_CMD_OFS);
   wire wr_pend = wr_en && (wr.addr == VII_PEND_OFS);
   wire wr_leven = wr_en && (wr.addr == VII_LEVEN_OFS);
   wire wr_iie = wr_en && (wr.addr == VII_IIE_OFS);
   wire [15:0] iie_merge = vii_merge16({5'h00, internal_source_enable}, wr.data, wr.strb);
   wire wr_ident = wr_en && (wr.addr == VII_IDENT_OFS);
   wire wr_irq_stat = wr_en && (wr.addr == VII_IRQ_STAT_OFS);
   wire wr_irq_mask = wr_en && (wr.addr == VII_IRQ_MASK_OFS);
   wire rd_iic = rd_en && (rd_addr == VII_IIC_OFS);
   wire rd_pes = rd_en && (rd_addr == VII_PES_OFS);
   wire cmd_on = wr_cmd && wr.strb[0] && wr.data[VII_CMD_ON_BIT];
   wire cmd_off = wr_cmd && wr.strb[0] && wr.data[VII_CMD_OFF_BIT];
   wire cmd_giveup = wr_cmd && wr.strb[0] && wr.data[VII_CMD_GIVEUP_BIT];
   wire ident_level_ok = (wr.data[3:0] >= VII_LEVEL_VEC_LO) && (wr.data[3:0] <= VII_LEVEL_VEC_HI);
   wire ident_start = wr_ident && wr.strb[0] && ident_level_ok && (ident_state == VII_IDLE);
   wire ident_got = (ident_state == VII_ASK) && ready_s;
   wire timer_done = (timer == 16'h0000);
   // silent bus gives io exchange error
   wire iox_error = (ident_state == VII_ASK) && !ready_s && timer_done;
   wire [10:0] event_all = event_s | (11'(iox_error) << VII_IOX_SRC_BIT);
   wire [10:0] event_on = event_all & internal_source_enable;
   wire level_change = interrupts_on && (next_top != current_level);

   // ********
   // Read selection
   // ********
   // Parity address reads zero while blocked so stale power-up content never leaks
   wire [31:0] status_word = {16'h0000, 2'h0, regs_blocked, ident_state != VII_IDLE, previous_level_reg,
                              current_level, 3'h0, interrupts_on};
   assign rd_data =
      (rd_addr == VII_STATUS_OFS) ? status_word :
      (rd_addr == VII_PEND_OFS) ? {16'h0, pending_level_flags} :
      (rd_addr == VII_LEVEN_OFS) ? {16'h0, level_enable_mask} :
      (rd_addr == VII_IIE_OFS) ? {21'h0, internal_source_enable} :
      (rd_addr == VII_IIC_OFS) ? {28'h0, internal_cause_code} :
      (rd_addr == VII_PES_OFS) ? {16'h0, parity_fault_status} :
      (rd_addr == VII_PEA_OFS) ? {16'h0, regs_blocked ? 16'h0 : parity_fault_address} :
      (rd_addr == VII_VECTOR_OFS) ? {vector_valid, 31'(branch_vector)} :
      (rd_addr == VII_IRQ_STAT_OFS) ? {28'h0, irq_status} :
      (rd_addr == VII_IRQ_MASK_OFS) ? {28'h0, irq_mask} :
      (rd_addr == VII_PREV_OFS) ? {28'h0, previous_level_reg} : 32'h0;

   // ********
   // Level arbitration and cause priority
   // ********
   // highest pending and enabled level
   always_comb begin
      next_top = current_level;
      if (|(pending_level_flags & level_enable_mask)) begin
         next_top = VII_RESET_LEVEL;
         for (int i = 0; i < 16; i++) begin
            if (pending_level_flags[i] && level_enable_mask[i]) begin
               next_top = 4'(i);
            end
         end
      end
   end

   // Highest source bit wins, so power fail beats the rest
   always_comb begin
      next_cause = VII_RESET_LEVEL;
      for (int i = 0; i < 11; i++) begin
         if (event_on[i]) begin
            next_cause = 4'(i);
         end
      end
   end

   // Pending flags: software edits first, hardware sets last so a set is never lost
   always_comb begin
      next_pending = pending_level_flags;
      if (wr_pend) begin
         next_pending = vii_merge16(pending_level_flags, wr.data, wr.strb);
      end
      if (cmd_giveup) begin
         next_pending[current_level] = 1'b0;
      end
      next_pending[13:10] = next_pending[13:10] | dev_req_s;
      if (|event_on) begin
         next_pending[VII_LEVEL_INTERNAL] = 1'b1;
      end
   end

   // ********
   // Interrupt system and level registers
   // ********
   // all masks and level clear at reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pending_level_flags <= VII_RESET_WORD;
         level_enable_mask <= VII_RESET_WORD;
         internal_source_enable <= 11'h000;
         interrupts_on <= 1'b0;
         current_level <= VII_RESET_LEVEL;
         previous_level_reg <= VII_RESET_LEVEL;
      end else begin
         pending_level_flags <= next_pending;
         if (wr_leven) begin
            level_enable_mask <= vii_merge16(level_enable_mask, wr.data, wr.strb);
         end
         if (wr_iie) begin
            internal_source_enable <= iie_merge[10:0];
         end
         if (cmd_on) begin
            interrupts_on <= 1'b1;
         end else if (cmd_off) begin
            interrupts_on <= 1'b0;
         end
         if (level_change) begin
            current_level <= next_top;
            if (next_top == VII_LEVEL_INTERNAL) begin
               previous_level_reg <= current_level;
            end
         end
      end
   end

   // ********
   // Internal cause and parity capture
   // ********
   // Blocked registers hold still until software reads both cause and status
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         internal_cause_code <= VII_RESET_LEVEL;
         parity_fault_status <= VII_RESET_WORD;
         parity_fault_address <= VII_RESET_WORD;
         regs_blocked <= 1'b1;
         cause_read_seen <= 1'b0;
         status_read_seen <= 1'b0;
      end else begin
         if (rd_iic) begin
            cause_read_seen <= 1'b1;
         end
         if (rd_pes) begin
            status_read_seen <= 1'b1;
         end
         if ((cause_read_seen || rd_iic) && (status_read_seen || rd_pes)) begin
            regs_blocked <= 1'b0;
         end
         if (!regs_blocked && (|event_on)) begin
            internal_cause_code <= next_cause;
         end else if (rd_iic) begin
            internal_cause_code <= VII_RESET_LEVEL;
         end
         if (!regs_blocked && (event_on[VII_PTY_SRC_BIT] || event_on[VII_MOR_SRC_BIT])) begin
            parity_fault_status <= pstat_s;
            parity_fault_address <= paddr_s;
         end
      end
   end

   // ********
   // Identify search
   // ********
   assign ident_request = (ident_state == VII_ASK);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ident_state <= VII_IDLE;
         ident_level <= 2'h0;
         timer <= 16'h0000;
         branch_vector <= '0;
         vector_valid <= 1'b0;
      end else begin
         case (ident_state)
            VII_IDLE: begin
               if (ident_start) begin
                  ident_state <= VII_ASK;
                  ident_level <= wr.data[1:0] ^ VII_LEVEL_VEC_LO[1:0];
                  timer <= 16'(TIMEOUT_CYCLES - 1);
                  vector_valid <= 1'b0;
               end
            end
            VII_ASK: begin
               timer <= timer - 16'h0001;
               // 11-bit code kept as branch value
               if (ready_s) begin
                  branch_vector <= code_s;
                  vector_valid <= 1'b1;
                  ident_state <= VII_RELEASE;
                  timer <= 16'(TIMEOUT_CYCLES - 1);
               end else if (timer_done) begin
                  ident_state <= VII_IDLE;
               end
            end
            VII_RELEASE: begin
               // Wait for the reply to drop, but never hang on a stuck line
               timer <= timer - 16'h0001;
               if (!ready_s || timer_done) begin
                  ident_state <= VII_IDLE;
               end
            end
            default: begin
               ident_state <= VII_IDLE;
            end
         endcase
      end
   end

   // ********
   // Interrupt status, mask and output
   // ********
   // Write one to clear; a new event in the same cycle keeps its bit
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_status <= VII_RESET_IRQ;
         irq_mask <= VII_RESET_IRQ;
      end else begin
         irq_status <= (irq_status & ~(wr_irq_stat && wr.strb[0] ? wr.data[3:0] : 4'h0))
                       | (4'(ident_got) << VII_IRQ_IDENT_BIT)
                       | (4'(iox_error) << VII_IRQ_IOX_BIT)
                       | (4'(level_change) << VII_IRQ_LEVEL_BIT)
                       | (4'(|event_on) << VII_IRQ_INTERNAL_BIT);
         if (wr_irq_mask && wr.strb[0]) begin
            irq_mask <= wr.data[3:0];
         end
      end
   end

   assign irq = |(irq_status & irq_mask);
endmodule
`default_nettype wire

// ===== vii_assertions.sv
`timescale 1ns/1ns
`default_nettype none
// ********
// Port checker
// ********
module vii_assertions
   import vii_pkg::*;
#(
   parameter int CODE_W = 11,
   parameter int TIMEOUT_CYCLES = VII_IDENT_TIMEOUT_CYCLES
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_bvalid,
   input wire logic ident_request,
   input wire logic [1:0] ident_level,
   input wire logic [CODE_W-1:0] ident_code,
   input wire logic bus_data_ready_reply,
   input wire logic [3:0] current_level,
   input wire logic interrupts_on,
   input wire logic [CODE_W-1:0] branch_vector
);
   // Timeout plus sync delay
   localparam int REL_MAX = TIMEOUT_CYCLES + 4;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_reset_state; !$past(aresetn) |-> current_level == VII_RESET_LEVEL && !interrupts_on; endproperty
   a_reset_state: assert property (p_reset_state) else $error("state after reset");
   property p_level_frozen; !interrupts_on && !$past(interrupts_on) |-> $stable(current_level); endproperty
   a_level_frozen: assert property (p_level_frozen) else $error("level moved while off");
   property p_ident_start; $rose(ident_request) |-> s_axi_bvalid || $past(s_axi_bvalid); endproperty
   a_ident_start: assert property (p_ident_start) else $error("search without write");
   property p_ident_release; ident_request && bus_data_ready_reply |-> ##[1:6] !ident_request; endproperty
   a_ident_release: assert property (p_ident_release) else $error("search not ended");
   property p_ident_bound; $rose(ident_request) |-> ##[1:REL_MAX] !ident_request; endproperty
   a_ident_bound: assert property (p_ident_bound) else $error("search never gives up");
   property p_branch_code; $fell(ident_request) && bus_data_ready_reply |-> branch_vector == ident_code; endproperty
   a_branch_code: assert property (p_branch_code) else $error("vector not the code");
   property p_branch_hold; !ident_request && !$past(ident_request) |-> $stable(branch_vector); endproperty
   a_branch_hold: assert property (p_branch_hold) else $error("vector moved");
   property p_level_held; ident_request && $past(ident_request) |-> $stable(ident_level); endproperty
   a_level_held: assert property (p_level_held) else $error("search level moved");
endmodule
bind vii_top vii_assertions #(.CODE_W(CODE_W), .TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_chk (.aclk, .aresetn,
   .s_axi_bvalid, .ident_request, .ident_level, .ident_code, .bus_data_ready_reply, .current_level,
   .interrupts_on, .branch_vector);
`default_nettype wire

// ===== vii_dev_model.sv
`timescale 1ns/1ns
`default_nettype none
// ********
// Device interfaces
// ********
module vii_dev_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ident_request,
   input wire logic [1:0] ident_level,
   input wire logic [3:0] raise,
   input wire logic [3:0] delay,
   output logic [3:0] dev_request,
   output logic [10:0] ident_code,
   output logic bus_data_ready_reply
);
   logic [10:0] code = 11'h000;
   logic [3:0] cnt;
   // Released code lines show the inverse, so a late sample cannot match
   assign ident_code = bus_data_ready_reply ? code : ~code;
   always @(posedge aclk) begin
      if (!aresetn) begin
         dev_request <= 4'h0;
         bus_data_ready_reply <= 1'h0;
         cnt <= 4'h0;
      end else begin
         dev_request <= dev_request | raise;
         if (!ident_request) begin
            bus_data_ready_reply <= 1'h0;
            cnt <= 4'h0;
         end else if (dev_request[ident_level] && !bus_data_ready_reply) begin
            cnt <= cnt + 4'h1;
            if (cnt == delay) begin
               bus_data_ready_reply <= 1'h1;
               code <= {9'h040, ident_level};
               dev_request[ident_level] <= 1'h0;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ===== tb_vectored_interrupt_identify.sv
`timescale 1ns/1ns
`default_nettype none
// ********
// Bench
// ********
module tb_vectored_interrupt_identify import vii_pkg::*;;
   logic aclk, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid, ident_request, bus_data_ready_reply, interrupts_on, irq;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, got;
   logic [3:0] s_axi_wstrb = 4'hF, raise = 4'h0, delay = 4'h2, dev_request, current_level;
   logic [10:0] internal_event = 11'h000, ident_code, branch_vector;
   logic [15:0] parity_status_in = 16'h0000, parity_address_in = 16'h0000;
   logic [1:0] s_axi_bresp, s_axi_rresp, ident_level, rsp;
   int n_mismatch = 0, num_checks = 0;
   vii_top #(.TIMEOUT_CYCLES(8)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .dev_request, .internal_event, .parity_status_in, .parity_address_in, .ident_request, .ident_level,
      .ident_code, .bus_data_ready_reply, .current_level, .interrupts_on, .branch_vector, .irq);
   vii_dev_model dev (.aclk, .aresetn, .ident_request, .ident_level, .raise, .delay, .dev_request,
      .ident_code, .bus_data_ready_reply);
   // Free running clock
   initial begin
      aclk = 1'h0;
      forever #25 aclk = ~aclk;
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Bus tasks start just after an edge; each channel drops when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
         if (s_axi_bready && s_axi_bvalid) begin
            s_axi_bready <= 1'h0;
            rsp = s_axi_bresp;
         end
      end while (s_axi_awvalid || s_axi_wvalid || s_axi_bready);
   endtask
   task automatic rd(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
         if (s_axi_rready && s_axi_rvalid) begin
            s_axi_rready <= 1'h0;
            got = s_axi_rdata;
            rsp = s_axi_rresp;
         end
      end while (s_axi_arvalid || s_axi_rready);
   endtask
   task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
      rd(a);
      chk(nm, got, exp);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic ident(input logic [31:0] lv);
      wr(VII_IDENT_OFS, lv);
      idle(12);
   endtask
   task automatic pulse(input logic [3:0] r);
      raise <= r;
      @(posedge aclk);
      raise <= 4'h0;
      idle(6);
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // About twenty times the whole run
   initial begin
      #150000;
      n_mismatch++;
      report_and_stop();
   end
   // Test sequence
   initial begin
      idle(2);
      aresetn <= 1'h1;
      idle(1);
      chk("level", current_level, VII_RESET_LEVEL);
      rchk("status", VII_STATUS_OFS, 32'h0000_2000);
      rchk("leven", VII_LEVEN_OFS, 32'h0);
      rchk("iie", VII_IIE_OFS, 32'h0);
      rchk("hole", 8'h34, 32'h0);
      chk("rresp", rsp, VII_RESP_SLVERR);
      wr(8'h34, 32'h0);
      chk("bresp", rsp, VII_RESP_SLVERR);
      $display("test reset done");
      // masks first, io exchange error source on, on last
      wr(VII_LEVEN_OFS, 32'h0000_7C00);
      wr(VII_IIE_OFS, 32'h0000_0080);
      rd(VII_IIC_OFS);
      rd(VII_PES_OFS);
      rchk("status", VII_STATUS_OFS, 32'h0);
      wr(VII_IRQ_MASK_OFS, 32'hF);
      wr(VII_CMD_OFS, 32'h1);
      chk("on", interrupts_on, 1'h1);
      pulse(4'h4);
      chk("level", current_level, 4'hC);
      rchk("pend", VII_PEND_OFS, 32'h0000_1000);
      ident(32'hC);
      chk("vector", branch_vector, 11'h102);
      rchk("vecreg", VII_VECTOR_OFS, 32'h8000_0102);
      wr(VII_CMD_OFS, 32'h4);
      rchk("pend", VII_PEND_OFS, 32'h0);
      chk("irq", irq, 1'h1);
      wr(VII_IRQ_MASK_OFS, 32'h0);
      chk("irq", irq, 1'h0);
      wr(VII_IRQ_STAT_OFS, 32'hF);
      wr(VII_IRQ_MASK_OFS, 32'hF);
      chk("irq", irq, 1'h0);
      $display("test identify done");
      delay <= 4'h0;
      pulse(4'h8);
      ident(32'hA);
      chk("level", current_level, 4'hE);
      rchk("prev", VII_PREV_OFS, 32'hD);
      rchk("cause", VII_IIC_OFS, 32'h7);
      rchk("cause", VII_IIC_OFS, 32'h0);
      rd(VII_IRQ_STAT_OFS);
      chk("ioerr", got & 32'h2, 32'h2);
      wr(VII_CMD_OFS, 32'h2);
      wr(VII_PEND_OFS, 32'h0);
      idle(3);
      chk("level", current_level, 4'hE);
      wr(VII_CMD_OFS, 32'h1);
      idle(3);
      chk("level", current_level, 4'hD);
      $display("test timeout done");
      report_and_stop();
   end
endmodule
`default_nettype wire
